// File: sce_disp.sv
// Error code to display digits
`timescale 1ns/100ps
`default_nettype none
module sce_disp
	import sce_pkg::*;
(
	input  wire logic [5:0] code,
	output logic            prefix_on,
	output logic      [3:0] tens,
	output logic      [3:0] units
);
	always_comb begin
		prefix_on = (code != ERR_NONE);
		if (code >= 6'd10) begin
			tens  = 4'h1;
			units = 4'(code - 6'd10);
		end else begin
			tens  = 4'h0;
			units = code[3:0];
		end
	end
endmodule
`default_nettype wire

// File: sce_host_model.sv
// Host master model issuing register requests
`timescale 1ns/100ps
`default_nettype none
module sce_host_model (
	input  wire logic        sys_clk,
	output logic             req_valid,
	output logic      [7:0]  req_func,
	output logic      [15:0] req_addr,
	output logic      [15:0] req_data
);
	initial begin
		req_valid = 1'b0;
		req_func  = 8'h5a;
		req_addr  = 16'ha5a5;
		req_data  = 16'h5a5a;
	end
	// ==========================================
	// One request, lines scrambled once released
	task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_func  <= f;
		req_addr  <= a;
		req_data  <= d;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		req_func  <= ~f;
		req_addr  <= ~a;
		req_data  <= ~d;
	endtask
endmodule
`default_nettype wire

// File: sce_pkg.sv
// Constants and helpers for the setup and communication error checker
// Function
// - Both sources on input one: code 1
// - Both sources on input two: code 2
// - Cooling output two conflicts output one: code 4
// - Unit mismatch with dependent sources: code 5
// - Unit mismatch with difference alarm: code 5
// - Output two alarm, alarm two none: code 6
// - Alarm two none drives no output two
// - Dwell timer on both alarms: code 7
// - Unsupported function code: reject, code 10
// - Address out of range: reject, code 11
// - Missing parameter: reject, code 12
// - Write read-only or protected: code 14
// - Write value out of range: code 15
package sce_pkg;
	// ==========================================
	// APB map
	localparam logic [7:0] OFS_SRC      = 8'h00;
	localparam logic [7:0] OFS_INP      = 8'h04;
	localparam logic [7:0] OFS_ALM      = 8'h08;
	localparam logic [7:0] OFS_PB       = 8'h0c;
	localparam logic [7:0] OFS_TI       = 8'h10;
	localparam logic [7:0] OFS_ERR      = 8'h14;
	localparam logic [7:0] OFS_INT_STAT = 8'h18;
	localparam logic [7:0] OFS_INT_EN   = 8'h1c;
	localparam logic [7:0] OFS_INT_CLR  = 8'h20;
	localparam int         INT_SETUP    = 0;
	localparam int         INT_COMM     = 1;
	// ==========================================
	// Setting encodings
	localparam logic [1:0] PV_IN1    = 2'h0;
	localparam logic [1:0] PV_IN2    = 2'h1;
	localparam logic [1:0] PV_D12    = 2'h2;
	localparam logic [1:0] PV_D21    = 2'h3;
	localparam logic [1:0] SP_LOCAL  = 2'h0;
	localparam logic [1:0] SP_IN1    = 2'h1;
	localparam logic [1:0] SP_IN2    = 2'h2;
	localparam logic [1:0] SEC_OFF   = 2'h0;
	localparam logic [1:0] SEC_COOL  = 2'h1;
	localparam logic [1:0] SEC_ALM2  = 2'h2;
	localparam logic [3:0] ALM_NONE  = 4'h0;
	localparam logic [3:0] ALM_TIMER = 4'h1;
	localparam logic [3:0] ALM_DH    = 4'h2;
	localparam logic [3:0] ALM_DL    = 4'h3;
	localparam logic [3:0] ALM_DDH   = 4'h4;
	localparam logic [3:0] ALM_DDL   = 4'h5;
	localparam logic [3:0] ALM_MAX   = 4'h9;
	// ==========================================
	// Error codes
	localparam logic [5:0] ERR_NONE  = 6'h00;
	localparam logic [5:0] ERR_IN1   = 6'h01;
	localparam logic [5:0] ERR_IN2   = 6'h02;
	localparam logic [5:0] ERR_DEP   = 6'h03;
	localparam logic [5:0] ERR_COOL  = 6'h04;
	localparam logic [5:0] ERR_UNIT  = 6'h05;
	localparam logic [5:0] ERR_ALM2  = 6'h06;
	localparam logic [5:0] ERR_DWELL = 6'h07;
	localparam logic [5:0] ERR_FUNC  = 6'h0a;
	localparam logic [5:0] ERR_ADDR  = 6'h0b;
	localparam logic [5:0] ERR_PARAM = 6'h0c;
	localparam logic [5:0] ERR_RO    = 6'h0e;
	localparam logic [5:0] ERR_VAL   = 6'h0f;
	// ==========================================
	// Host request map
	localparam logic [7:0]  FN_READ     = 8'h03;
	localparam logic [7:0]  FN_WRITE    = 8'h06;
	localparam logic [15:0] HOST_LIMIT  = 16'h0020;
	localparam logic [15:0] HOST_FIELDS = 16'h0010;
	localparam logic [15:0] HIDX_ERR    = 16'h000e;
	function automatic logic [15:0] sce_host_max(input logic [3:0] idx);
		case (idx)
			4'h0: sce_host_max = 16'h0003;
			4'h1: sce_host_max = 16'h0002;
			4'h2: sce_host_max = 16'h0001;
			4'h3: sce_host_max = 16'h0002;
			4'h8, 4'h9: sce_host_max = {12'h000, ALM_MAX};
			4'ha, 4'hb, 4'hc, 4'hd: sce_host_max = 16'hffff;
			default: sce_host_max = 16'h0003;
		endcase
	endfunction
endpackage

// File: sce_setup_chk.sv
// Setup consistency checks, lowest active code first
`timescale 1ns/100ps
`default_nettype none
module sce_setup_chk
	import sce_pkg::*;
(
	input  wire logic [1:0]  pv_src,
	input  wire logic [1:0]  sp_src,
	input  wire logic        direct_act,
	input  wire logic [1:0]  sec_out,
	input  wire logic [1:0]  in1_unit,
	input  wire logic [1:0]  in2_unit,
	input  wire logic [1:0]  dp_one,
	input  wire logic [1:0]  dp_two,
	input  wire logic [3:0]  alm1_fn,
	input  wire logic [3:0]  alm2_fn,
	input  wire logic [15:0] pba,
	input  wire logic [15:0] pbb,
	input  wire logic [15:0] tia,
	input  wire logic [15:0] tib,
	output logic      [5:0]  code
);
	logic pv_diff;
	logic sp_inp;
	logic mism;
	logic no_pid;
	logic alm_diff;
	always_comb begin
		pv_diff  = (pv_src == PV_D12) || (pv_src == PV_D21);
		sp_inp   = (sp_src == SP_IN1) || (sp_src == SP_IN2);
		mism     = (in1_unit != in2_unit) || (dp_one != dp_two);
		no_pid   = ((pba == 16'h0000) || (pbb == 16'h0000)) && ((tia == 16'h0000) || (tib == 16'h0000));
		alm_diff = (alm1_fn inside {ALM_DH, ALM_DL, ALM_DDH, ALM_DDL})
			|| (alm2_fn inside {ALM_DH, ALM_DL, ALM_DDH, ALM_DDL});
		// Priority chain keeps the lowest code
		if (pv_src == PV_IN1 && sp_src == SP_IN1) code = ERR_IN1;
		else if (pv_src == PV_IN2 && sp_src == SP_IN2) code = ERR_IN2;
		else if (pv_diff && sp_inp) code = ERR_DEP;
		else if (sec_out == SEC_COOL && (direct_act || no_pid)) code = ERR_COOL;
		else if (mism && (pv_diff || sp_inp || alm_diff)) code = ERR_UNIT;
		else if (sec_out == SEC_ALM2 && alm2_fn == ALM_NONE) code = ERR_ALM2;
		else if (alm1_fn == ALM_TIMER && alm2_fn == ALM_TIMER) code = ERR_DWELL;
		else code = ERR_NONE;
	end
endmodule
`default_nettype wire

// File: sce_top.sv
// Setup and communication error checker with APB registers
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module sce_top
	import sce_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        req_valid,
	input  wire logic [7:0]  req_func,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_data,
	input  wire logic        setup_lock,
	output logic             rsp_valid,
	output logic      [5:0]  rsp_err,
	output logic      [15:0] rsp_data,
	input  wire logic        alarm_two_event,
	output logic             alarm_two_drive,
	output logic             disp_prefix_on,
	output logic      [3:0]  disp_tens,
	output logic      [3:0]  disp_units,
	output logic      [5:0]  err_code,
	output logic             irq
);
	typedef struct packed {
		logic [1:0]  pv_src;
		logic [1:0]  sp_src;
		logic        direct_act;
		logic [1:0]  sec_out;
		logic [1:0]  in1_unit;
		logic [1:0]  in2_unit;
		logic [1:0]  dp_one;
		logic [1:0]  dp_two;
		logic [3:0]  alm1_fn;
		logic [3:0]  alm2_fn;
		logic [15:0] pba;
		logic [15:0] pbb;
		logic [15:0] tia;
		logic [15:0] tib;
		logic [5:0]  setup_code;
		logic [5:0]  comm_code;
		logic [5:0]  shown_code;
		logic [1:0]  int_stat;
		logic [1:0]  int_en;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        rsp_valid;
		logic [5:0]  rsp_err;
		logic [15:0] rsp_data;
		logic        a2_drive;
		logic        disp_on;
		logic [3:0]  disp_tens;
		logic [3:0]  disp_units;
		logic        irq;
	} sce_state_t;

	sce_state_t state_r;
	sce_state_t state_nxt;
	logic [5:0]  chk_code;
	logic        dsp_on;
	logic [3:0]  dsp_tens;
	logic [3:0]  dsp_units;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        apb_fire;
	logic [5:0]  host_err;
	logic [15:0] host_rd;
	logic [3:0]  hidx;
	logic [1:0]  int_set;
	logic [1:0]  int_clr;

	// ==========================================
	// Submodules
	sce_setup_chk u_sce_setup_chk (
		.pv_src     (state_r.pv_src),
		.sp_src     (state_r.sp_src),
		.direct_act (state_r.direct_act),
		.sec_out    (state_r.sec_out),
		.in1_unit   (state_r.in1_unit),
		.in2_unit   (state_r.in2_unit),
		.dp_one     (state_r.dp_one),
		.dp_two     (state_r.dp_two),
		.alm1_fn    (state_r.alm1_fn),
		.alm2_fn    (state_r.alm2_fn),
		.pba        (state_r.pba),
		.pbb        (state_r.pbb),
		.tia        (state_r.tia),
		.tib        (state_r.tib),
		.code       (chk_code)
	);

	sce_disp u_sce_disp (
		.code      (state_r.shown_code),
		.prefix_on (dsp_on),
		.tens      (dsp_tens),
		.units     (dsp_units)
	);

	// ==========================================
	// APB read decode
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case (paddr)
			OFS_SRC: rd_word = {18'h0, state_r.sec_out, 3'h0, state_r.direct_act,
				2'h0, state_r.sp_src, 2'h0, state_r.pv_src};
			OFS_INP: rd_word = {18'h0, state_r.dp_two, 2'h0, state_r.dp_one, 2'h0,
				state_r.in2_unit, 2'h0, state_r.in1_unit};
			OFS_ALM: rd_word = {24'h0, state_r.alm2_fn, state_r.alm1_fn};
			OFS_PB: rd_word = {state_r.pbb, state_r.pba};
			OFS_TI: rd_word = {state_r.tib, state_r.tia};
			OFS_ERR: rd_word = {10'h0, state_r.comm_code, 2'h0, state_r.setup_code,
				2'h0, state_r.shown_code};
			OFS_INT_STAT: rd_word = {30'h0, state_r.int_stat};
			OFS_INT_EN: rd_word = {30'h0, state_r.int_en};
			OFS_INT_CLR: rd_word = 32'h0000_0000;
			default: rd_hit = 1'b0;
		endcase
	end

	// ==========================================
	// Host request checks
	always_comb begin
		hidx = req_addr[3:0];
		if (req_func != FN_READ && req_func != FN_WRITE) host_err = ERR_FUNC;
		else if (req_addr >= HOST_LIMIT) host_err = ERR_ADDR;
		else if (req_addr >= HOST_FIELDS) host_err = ERR_PARAM;
		else if (req_func == FN_WRITE && (req_addr >= HIDX_ERR || setup_lock)) host_err = ERR_RO;
		else if (req_func == FN_WRITE && req_data > sce_host_max(hidx)) host_err = ERR_VAL;
		else host_err = ERR_NONE;
		case (hidx)
			4'h0: host_rd = {14'h0, state_r.pv_src};
			4'h1: host_rd = {14'h0, state_r.sp_src};
			4'h2: host_rd = {15'h0, state_r.direct_act};
			4'h3: host_rd = {14'h0, state_r.sec_out};
			4'h4: host_rd = {14'h0, state_r.in1_unit};
			4'h5: host_rd = {14'h0, state_r.in2_unit};
			4'h6: host_rd = {14'h0, state_r.dp_one};
			4'h7: host_rd = {14'h0, state_r.dp_two};
			4'h8: host_rd = {12'h0, state_r.alm1_fn};
			4'h9: host_rd = {12'h0, state_r.alm2_fn};
			4'ha: host_rd = state_r.pba;
			4'hb: host_rd = state_r.pbb;
			4'hc: host_rd = state_r.tia;
			4'hd: host_rd = state_r.tib;
			4'he: host_rd = {10'h0, state_r.shown_code};
			default: host_rd = {14'h0, state_r.int_stat};
		endcase
	end

	// ==========================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		apb_fire  = psel && penable && state_r.pready;
		int_clr   = 2'h0;
		int_set   = 2'h0;
		state_nxt.pready    = 1'b0;
		state_nxt.pslverr   = 1'b0;
		state_nxt.rsp_valid = 1'b0;
		if (psel && penable && !state_r.pready) begin
			state_nxt.pready  = 1'b1;
			state_nxt.pslverr = !rd_hit;
			state_nxt.prdata  = rd_word;
		end
		// Host requests; a rejected one changes no setting
		if (req_valid) begin
			state_nxt.rsp_valid = 1'b1;
			state_nxt.rsp_err   = host_err;
			state_nxt.rsp_data  = (host_err == ERR_NONE) ? host_rd : 16'h0000;
			state_nxt.comm_code = host_err;
			int_set[INT_COMM]   = (host_err != ERR_NONE);
			if (host_err == ERR_NONE && req_func == FN_WRITE) begin
				case (hidx)
					4'h0: state_nxt.pv_src = req_data[1:0];
					4'h1: state_nxt.sp_src = req_data[1:0];
					4'h2: state_nxt.direct_act = req_data[0];
					4'h3: state_nxt.sec_out = req_data[1:0];
					4'h4: state_nxt.in1_unit = req_data[1:0];
					4'h5: state_nxt.in2_unit = req_data[1:0];
					4'h6: state_nxt.dp_one = req_data[1:0];
					4'h7: state_nxt.dp_two = req_data[1:0];
					4'h8: state_nxt.alm1_fn = req_data[3:0];
					4'h9: state_nxt.alm2_fn = req_data[3:0];
					4'ha: state_nxt.pba = req_data;
					4'hb: state_nxt.pbb = req_data;
					4'hc: state_nxt.tia = req_data;
					4'hd: state_nxt.tib = req_data;
					default: state_nxt.pba = state_r.pba;
				endcase
			end
		end
		// APB writes, taking precedence over a same-cycle host write
		if (apb_fire && pwrite) begin
			case (paddr)
				OFS_SRC: begin
					state_nxt.pv_src     = pwdata[1:0];
					state_nxt.sp_src     = pwdata[5:4];
					state_nxt.direct_act = pwdata[8];
					state_nxt.sec_out    = pwdata[13:12];
				end
				OFS_INP: begin
					state_nxt.in1_unit = pwdata[1:0];
					state_nxt.in2_unit = pwdata[5:4];
					state_nxt.dp_one   = pwdata[9:8];
					state_nxt.dp_two   = pwdata[13:12];
				end
				OFS_ALM: begin
					state_nxt.alm1_fn = pwdata[3:0];
					state_nxt.alm2_fn = pwdata[7:4];
				end
				OFS_PB: begin
					state_nxt.pba = pwdata[15:0];
					state_nxt.pbb = pwdata[31:16];
				end
				OFS_TI: begin
					state_nxt.tia = pwdata[15:0];
					state_nxt.tib = pwdata[31:16];
				end
				OFS_INT_EN: state_nxt.int_en = pwdata[1:0];
				OFS_INT_CLR: int_clr = pwdata[1:0];
				default: state_nxt.int_en = state_r.int_en;
			endcase
		end
		// Setup code held while its cause stays
		state_nxt.setup_code = chk_code;
		int_set[INT_SETUP] = (chk_code != ERR_NONE) && (chk_code != state_r.setup_code);
		state_nxt.shown_code = (chk_code != ERR_NONE) ? chk_code : state_nxt.comm_code;
		// Set wins over clear
		state_nxt.int_stat = (state_r.int_stat & ~int_clr) | int_set;
		state_nxt.irq      = |(state_nxt.int_stat & state_nxt.int_en);
		state_nxt.a2_drive = alarm_two_event && state_r.sec_out == SEC_ALM2
			&& state_r.alm2_fn != ALM_NONE;
		state_nxt.disp_on    = dsp_on;
		state_nxt.disp_tens  = dsp_tens;
		state_nxt.disp_units = dsp_units;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign prdata          = state_r.prdata;
	assign pready          = state_r.pready;
	assign pslverr         = state_r.pslverr;
	assign rsp_valid       = state_r.rsp_valid;
	assign rsp_err         = state_r.rsp_err;
	assign rsp_data        = state_r.rsp_data;
	assign alarm_two_drive = state_r.a2_drive;
	assign disp_prefix_on  = state_r.disp_on;
	assign disp_tens       = state_r.disp_tens;
	assign disp_units      = state_r.disp_units;
	assign err_code        = state_r.shown_code;
	assign irq             = state_r.irq;

	// ==========================================
	// Assertions
	sequence s_bad_func;
		req_valid && req_func != FN_READ && req_func != FN_WRITE;
	endsequence
	sequence s_ro_write;
		req_valid && req_func == FN_WRITE && req_addr == HIDX_ERR;
	endsequence
	property p_code1;
		@(posedge sys_clk) disable iff (rst)
		(state_r.pv_src == PV_IN1 && state_r.sp_src == SP_IN1) |=> state_r.setup_code == 6'h01;
	endproperty
	a_code1: assert property (p_code1) else $error("code 1 missing");
	property p_code2;
		@(posedge sys_clk) disable iff (rst)
		(state_r.pv_src == PV_IN2 && state_r.sp_src == SP_IN2) |=> state_r.setup_code == 6'h02;
	endproperty
	a_code2: assert property (p_code2) else $error("code 2 missing");
	property p_code3;
		@(posedge sys_clk) disable iff (rst)
		(state_r.pv_src[1] && (state_r.sp_src == SP_IN1 || state_r.sp_src == SP_IN2))
		|=> state_r.setup_code == 6'h03;
	endproperty
	a_code3: assert property (p_code3) else $error("code 3 missing");
	property p_code4;
		@(posedge sys_clk) disable iff (rst)
		(state_r.sec_out == SEC_COOL && state_r.direct_act) |=> state_r.setup_code inside {[1:4]};
	endproperty
	a_code4: assert property (p_code4) else $error("code 4 missing");
	property p_code6;
		@(posedge sys_clk) disable iff (rst)
		(state_r.sec_out == SEC_ALM2 && state_r.alm2_fn == ALM_NONE) |=> state_r.setup_code inside {[1:6]};
	endproperty
	a_code6: assert property (p_code6) else $error("code 6 missing");
	property p_a2_quiet;
		@(posedge sys_clk) disable iff (rst)
		state_r.alm2_fn == ALM_NONE ##1 state_r.alm2_fn == ALM_NONE |-> !alarm_two_drive;
	endproperty
	a_a2_quiet: assert property (p_a2_quiet) else $error("alarm two driven");
	property p_code7;
		@(posedge sys_clk) disable iff (rst)
		(state_r.alm1_fn == ALM_TIMER && state_r.alm2_fn == ALM_TIMER) |=> state_r.setup_code inside {[1:7]};
	endproperty
	a_code7: assert property (p_code7) else $error("code 7 missing");
	property p_func;
		@(posedge sys_clk) disable iff (rst)
		s_bad_func |=> rsp_valid && rsp_err == 6'h0a;
	endproperty
	a_func: assert property (p_func) else $error("bad function not rejected");
	property p_addr;
		@(posedge sys_clk) disable iff (rst)
		(req_valid && req_func == FN_READ && req_addr >= HOST_LIMIT) |=> rsp_err == 6'h0b;
	endproperty
	a_addr: assert property (p_addr) else $error("address not rejected");
	property p_ro;
		@(posedge sys_clk) disable iff (rst)
		s_ro_write |=> rsp_err == 6'h0e && $stable(state_r.pba);
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write not rejected");
	property p_shown;
		@(posedge sys_clk) disable iff (rst)
		state_r.setup_code != 6'h00 |-> err_code == state_r.setup_code ##1 disp_prefix_on;
	endproperty
	a_shown: assert property (p_shown) else $error("setup code not shown");
endmodule
`default_nettype wire

// File: test_setup_and_comm_error_checker.sv
// Self-checking testbench of the setup and communication error checker
`timescale 1ns/100ps
`default_nettype none
module test_setup_and_comm_error_checker;
	import sce_pkg::*;
	logic        sys_clk, rst, psel, penable, pwrite, setup_lock, alarm_two_event;
	logic        pready, pslverr, req_valid, rsp_valid, alarm_two_drive, disp_prefix_on, irq;
	logic [7:0]  paddr, req_func;
	logic [31:0] pwdata, prdata;
	logic [15:0] req_addr, req_data, rsp_data;
	logic [5:0]  rsp_err, err_code;
	logic [3:0]  disp_tens, disp_units;
	logic [32:0] q_rd[$];
	logic [22:0] q_rsp[$];
	int          err_total = 0;
	int          num_checks = 0;

	sce_top u_sce_top (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req_valid(req_valid), .req_func(req_func), .req_addr(req_addr), .req_data(req_data),
		.setup_lock(setup_lock), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
		.alarm_two_event(alarm_two_event), .alarm_two_drive(alarm_two_drive),
		.disp_prefix_on(disp_prefix_on), .disp_tens(disp_tens), .disp_units(disp_units),
		.err_code(err_code), .irq(irq)
	);
	sce_host_model u_sce_host_model (
		.sys_clk(sys_clk), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
		.req_data(req_data)
	);

	// ==========================================
	// Checking and closing
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		logic [22:0] e;
		if (rsp_valid === 1'b1) begin
			e = (q_rsp.size() > 0) ? q_rsp.pop_front() : 23'h7fffff;
			chk({e[22], rsp_err, e[22] ? rsp_data : 16'h0}, e);
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk({pslverr, prdata}, (q_rd.size() > 0) ? q_rd.pop_front() : 33'h1ffffffff);
		end
	end

	// ==========================================
	// Bus and request tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk(1'b0, 1'b1);
			conclude();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q_rd.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic hq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
		input logic care, input logic [5:0] e, input logic [15:0] ed);
		q_rsp.push_back({care, e, ed});
		u_sce_host_model.send(f, a, d);
	endtask
	task automatic setup_case(input logic [31:0] s, input logic [31:0] i, input logic [31:0] al,
		input logic [31:0] pb, input logic [5:0] c);
		apb(1'b1, OFS_SRC, s);
		apb(1'b1, OFS_INP, i);
		apb(1'b1, OFS_ALM, al);
		apb(1'b1, OFS_PB, pb);
		apb(1'b1, OFS_TI, pb);
		repeat (4) @(posedge sys_clk);
		rd(OFS_ERR, {1'b0, 18'h0, c, 2'h0, c});
		chk(err_code, c);
		chk({disp_prefix_on, disp_tens, disp_units}, {c != 6'h0, 4'(c / 6'h0a), 4'(c % 6'h0a)});
	endtask

	// ==========================================
	// Clock and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		int          m;
		logic [7:0]  f;
		logic [15:0] d;
		{psel, penable, pwrite, setup_lock, alarm_two_event} = 5'h0;
		paddr  = 8'h0;
		pwdata = 32'h0;
		rst    = 1'b1;
		void'($urandom(32'h52e73bda));
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		for (m = 0; m <= 32; m += 4) rd(8'(m), 33'h0);
		rd(8'h24, {1'b1, 32'h0});
		apb(1'b1, OFS_ERR, 32'hffffffff);
		rd(OFS_ERR, 33'h0);
		alarm_two_event <= 1'b1;
		setup_case(32'h10, 0, 0, 0, ERR_IN1);
		setup_case(32'h21, 0, 0, 0, ERR_IN2);
		setup_case(32'h12, 0, 0, 0, ERR_DEP);
		setup_case(32'h23, 0, 0, 0, ERR_DEP);
		setup_case(32'h1100, 0, 0, 32'h00010001, ERR_COOL);
		setup_case(32'h1000, 0, 0, 0, ERR_COOL);
		setup_case(32'h1000, 0, 0, 32'h00010001, ERR_NONE);
		setup_case(32'h3, 32'h1, 0, 0, ERR_UNIT);
		setup_case(32'h11, 32'h100, 0, 0, ERR_UNIT);
		setup_case(32'h0, 32'h1, 0, 0, ERR_NONE);
		for (m = 2; m <= 5; m++) setup_case(0, m[0] ? 32'h10 : 32'h1000, m[0] ? m : m << 4, 0, ERR_UNIT);
		setup_case(32'h2000, 0, 0, 0, ERR_ALM2);
		chk(alarm_two_drive, 1'b0);
		setup_case(0, 0, 32'h11, 0, ERR_DWELL);
		setup_case(32'h2021, 0, 32'h11, 0, ERR_IN2);
		setup_case(32'h2000, 0, 32'h20, 0, ERR_NONE);
		chk(alarm_two_drive, 1'b1);
		rd(OFS_INT_STAT, 33'h1);
		chk(irq, 1'b0);
		apb(1'b1, OFS_INT_EN, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk(irq, 1'b1);
		apb(1'b1, OFS_INT_CLR, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk(irq, 1'b0);
		rd(OFS_INT_STAT, 33'h0);
		apb(1'b1, OFS_INT_EN, 32'h3);
		hq(FN_WRITE, 16'h0, 16'h2, 1'b0, ERR_NONE, 16'h0);
		hq(FN_READ, 16'h0, 16'h0, 1'b1, ERR_NONE, 16'h2);
		f = 8'($urandom);
		if (f == FN_READ || f == FN_WRITE) f = 8'h07;
		hq(f, 16'h0, 16'h0, 1'b1, ERR_FUNC, 16'h0);
		hq(8'h04, 16'h20, 16'h0, 1'b1, ERR_FUNC, 16'h0);
		hq(FN_READ, 16'h20, 16'h0, 1'b1, ERR_ADDR, 16'h0);
		hq(FN_READ, 16'hffff, 16'h0, 1'b1, ERR_ADDR, 16'h0);
		hq(FN_WRITE, 16'h10, 16'h0, 1'b1, ERR_PARAM, 16'h0);
		hq(FN_READ, 16'h1f, 16'h0, 1'b1, ERR_PARAM, 16'h0);
		hq(FN_WRITE, 16'he, 16'h0, 1'b1, ERR_RO, 16'h0);
		hq(FN_WRITE, 16'hf, 16'h0, 1'b1, ERR_RO, 16'h0);
		setup_lock <= 1'b1;
		hq(FN_WRITE, 16'h0, 16'h1, 1'b1, ERR_RO, 16'h0);
		setup_lock <= 1'b0;
		hq(FN_READ, 16'h0, 16'h0, 1'b1, ERR_NONE, 16'h2);
		hq(FN_WRITE, 16'h8, 16'ha, 1'b1, ERR_VAL, 16'h0);
		hq(FN_WRITE, 16'h9, 16'h9, 1'b0, ERR_NONE, 16'h0);
		hq(FN_READ, 16'h9, 16'h0, 1'b1, ERR_NONE, 16'h9);
		d = 16'($urandom);
		hq(FN_WRITE, 16'ha, d, 1'b0, ERR_NONE, 16'h0);
		hq(FN_READ, 16'ha, 16'h0, 1'b1, ERR_NONE, d);
		rd(OFS_PB, {17'h0, d});
		hq(FN_WRITE, 16'h0, 16'h4, 1'b1, ERR_VAL, 16'h0);
		repeat (4) @(posedge sys_clk);
		rd(OFS_ERR, {1'b0, 32'h000f000f});
		chk(err_code, ERR_VAL);
		chk({disp_prefix_on, disp_tens, disp_units}, 9'h115);
		chk(irq, 1'b1);
		rd(OFS_INT_STAT, 33'h2);
		repeat (4) @(posedge sys_clk);
		chk(q_rsp.size() + q_rd.size(), 33'h0);
		conclude();
	end
endmodule
`default_nettype wire
